// >>> src/adec_top.sv
`timescale 1ns/100ps
`include "adec_params.svh"
// Contract
// - RAM decoded whole, bank picked by A4
// - RAM select needs write low or read high
// - No RAM select before write strobe falls
// - High-RAM map: RAM F000, EPROM 0000
// - Low-RAM map: RAM 0000, EPROM high
// - Three jumper bits choose one of eight maps
// - Table holds 32 words per map, printed pattern
// - Table outputs active low
// - Address bit A0 most significant, lowest output bits least significant
// - A3-A9 decode into eight 32-word blocks
// - Block select three reserved, unattached
// - Onboard io space from A3-A6, cycle enable
// - Outside onboard space, external buffer enabled
// - Io map fixed logic, not programmable
// - Block selects drive fixed peripherals by index
// - Table off while memory cycle inactive
// - Table low inputs A0-A4, 1K-word blocks
// - Bit four RAM, bits three, two EPROM
// - Bit one low when any other low
module adec_top (
  input  wire logic                CORE_CLK,
  input  wire logic                RESETN,
  input  wire logic                CE,
  input  adec_pkg::adec_addr_t     ADDR,
  input  wire logic                MEMORY_CYCLE_N,
  input  wire logic                READ_STROBE,
  input  wire logic                WRITE_STROBE_N,
  input  adec_pkg::adec_map_t      MAP_SEL,
  output logic [1:0]               RAM_CS_N,
  output logic [1:0]               EPROM_CS_N,
  output logic                     ONBOARD_MEM_N,
  output logic                     ONBOARD_IO_SPACE,
  output logic                     EXT_IO_BUF_EN_N,
  output logic [7:0]               IO_BLOCK_SELECT_N
);
  import adec_pkg::*;

  adec_stage_s  stage_reg;
  adec_stage_s  stage_next;
  logic [1:0]   ram_cs_next;
  logic [1:0]   eprom_cs_next;
  logic         onboard_mem_next;
  logic         io_space_next;
  logic [7:0]   io_sel_next;
  adec_word_t   tbl;

  adec_tbl_if tbl_bus (
    .clk   (CORE_CLK),
    .rst_n (RESETN)
  );

  adec_rom u_rom (
    .port (tbl_bus.lut)
  );

  // Onboard io space test
  function automatic logic is_local_io(input logic mem_n, input logic [3:0] hi);
    return mem_n && (hi == `ADEC_IO_LOCAL);
  endfunction : is_local_io

  // Table index: jumpers high, top address bits low
  assign tbl_bus.ce    = CE;
  assign tbl_bus.index = {MAP_SEL, ADDR[0:4]};
  assign tbl           = tbl_bus.data;

  // Cycle classification, aligned with table read
  always_comb begin
    stage_next        = stage_reg;
    stage_next.a4     = ADDR[4];
    stage_next.mem_n  = MEMORY_CYCLE_N;
    stage_next.io_hi  = ADDR[3:6];
    stage_next.io_blk = ADDR[7:9];
    if (MEMORY_CYCLE_N) begin
      stage_next.kind = CYC_IO;
    end else if (!WRITE_STROBE_N) begin
      stage_next.kind = CYC_WRITE;
    end else if (READ_STROBE) begin
      stage_next.kind = CYC_READ;
    end else begin
      stage_next.kind = CYC_IDLE;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      stage_reg.kind   <= CYC_IDLE;
      stage_reg.a4     <= 1'b0;
      stage_reg.mem_n  <= 1'b1;
      stage_reg.io_hi  <= `ADEC_IO_HI_OFF;
      stage_reg.io_blk <= 3'h0;
    end else if (CE) begin
      stage_reg <= stage_next;
    end
  end

  // Memory enables from the table word
  always_comb begin
    ram_cs_next      = `ADEC_RAM_NONE;
    eprom_cs_next    = `ADEC_EPROM_NONE;
    onboard_mem_next = 1'b1;
    case (stage_reg.kind)
      CYC_READ, CYC_WRITE: begin
        if (!tbl[`ADEC_TBL_RAM]) begin
          ram_cs_next[stage_reg.a4] = 1'b0;
        end
      end
      CYC_IDLE, CYC_IO: begin
        ram_cs_next = `ADEC_RAM_NONE;
      end
      default: ram_cs_next = `ADEC_RAM_NONE;
    endcase
    if (!stage_reg.mem_n) begin
      eprom_cs_next    = {tbl[`ADEC_TBL_EPROM_HI], tbl[`ADEC_TBL_EPROM_LO]};
      onboard_mem_next = tbl[`ADEC_TBL_ONBOARD];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      RAM_CS_N      <= `ADEC_RAM_NONE;
      EPROM_CS_N    <= `ADEC_EPROM_NONE;
      ONBOARD_MEM_N <= 1'b1;
    end else if (CE) begin
      RAM_CS_N      <= ram_cs_next;
      EPROM_CS_N    <= eprom_cs_next;
      ONBOARD_MEM_N <= onboard_mem_next;
    end
  end

  // Fixed io block decode
  always_comb begin
    io_space_next = is_local_io(stage_reg.mem_n, stage_reg.io_hi);
    io_sel_next   = `ADEC_SEL_NONE;
    if (io_space_next) begin
      io_sel_next[stage_reg.io_blk] = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      ONBOARD_IO_SPACE  <= 1'b0;
      EXT_IO_BUF_EN_N   <= 1'b0;
      IO_BLOCK_SELECT_N <= `ADEC_SEL_NONE;
    end else if (CE) begin
      ONBOARD_IO_SPACE  <= io_space_next;
      EXT_IO_BUF_EN_N   <= io_space_next;
      IO_BLOCK_SELECT_N <= io_sel_next;
    end
  end

  // Checking helpers
  logic [1:0] hist;
  logic       live;

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      hist <= 2'h0;
    end else begin
      hist <= {hist[0], CE};
    end
  end

  assign live = (hist == 2'h3);

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  chk_ram_bank_pick: assert property (
    live && RAM_CS_N != `ADEC_RAM_NONE |->
      RAM_CS_N[0] == $past(ADDR[4], 2) && RAM_CS_N[1] == !$past(ADDR[4], 2))
    else $error("RAM bank does not follow A4");

  chk_ram_strobe_gate: assert property (
    live && RAM_CS_N != `ADEC_RAM_NONE |->
      !$past(MEMORY_CYCLE_N, 2) && (!$past(WRITE_STROBE_N, 2) || $past(READ_STROBE, 2)))
    else $error("RAM selected without strobe");

  chk_write_hold_off: assert property (
    live && !$past(MEMORY_CYCLE_N, 2) && $past(WRITE_STROBE_N, 2) && !$past(READ_STROBE, 2)
      |-> RAM_CS_N == `ADEC_RAM_NONE)
    else $error("RAM selected before write strobe");

  chk_high_ram_map: assert property (
    live && $past(MAP_SEL, 2) == `ADEC_MAP_HIGH_RAM_EPROM && !$past(MEMORY_CYCLE_N, 2)
      && $past(READ_STROBE, 2) |->
      ($past(ADDR[0:4], 2) == `ADEC_BLK_LAST ? RAM_CS_N != `ADEC_RAM_NONE : 1'b1) &&
      ($past(ADDR[0:4], 2) == `ADEC_BLK_FIRST ? EPROM_CS_N != `ADEC_EPROM_NONE : 1'b1))
    else $error("high RAM map misplaced");

  chk_low_ram_map: assert property (
    live && $past(MAP_SEL, 2) == `ADEC_MAP_LOW_RAM_EPROM && !$past(MEMORY_CYCLE_N, 2)
      && $past(READ_STROBE, 2) |->
      ($past(ADDR[0:4], 2) == `ADEC_BLK_FIRST ? RAM_CS_N != `ADEC_RAM_NONE : 1'b1) &&
      ($past(ADDR[0:4], 2) == `ADEC_BLK_LAST ? EPROM_CS_N != `ADEC_EPROM_NONE : 1'b1))
    else $error("low RAM map misplaced");

  chk_idle_mem_off: assert property (
    live && $past(MEMORY_CYCLE_N, 2) |->
      RAM_CS_N == `ADEC_RAM_NONE && EPROM_CS_N == `ADEC_EPROM_NONE && ONBOARD_MEM_N)
    else $error("memory enabled outside memory cycle");

  chk_onboard_or: assert property (
    RAM_CS_N != `ADEC_RAM_NONE || EPROM_CS_N != `ADEC_EPROM_NONE |-> !ONBOARD_MEM_N)
    else $error("onboard flag missing");

  chk_io_space_flag: assert property (
    live |-> ONBOARD_IO_SPACE ==
      ($past(MEMORY_CYCLE_N, 2) && $past(ADDR[3:6], 2) == `ADEC_IO_LOCAL))
    else $error("onboard io space wrong");

  chk_ext_buffer: assert property (
    live |-> EXT_IO_BUF_EN_N ==
      ($past(MEMORY_CYCLE_N, 2) && $past(ADDR[3:6], 2) == `ADEC_IO_LOCAL))
    else $error("external buffer enable wrong");

  chk_sel_exclusive: assert property (
    $onehot0(~IO_BLOCK_SELECT_N) &&
      (IO_BLOCK_SELECT_N != `ADEC_SEL_NONE ? ONBOARD_IO_SPACE : 1'b1))
    else $error("block selects not exclusive");

  chk_sel_index: assert property (
    live && ONBOARD_IO_SPACE |-> !IO_BLOCK_SELECT_N[$past(ADDR[7:9], 2)])
    else $error("wrong io block selected");

endmodule : adec_top

// >>> src/adec_params.svh
`ifndef ADEC_PARAMS_SVH
`define ADEC_PARAMS_SVH

// Table word bit positions
`define ADEC_TBL_RAM       3
`define ADEC_TBL_EPROM_HI  2
`define ADEC_TBL_EPROM_LO  1
`define ADEC_TBL_ONBOARD   0

// Idle and reset values, onboard io match value
`define ADEC_TBL_OFF       4'hF
`define ADEC_RAM_NONE      2'h3
`define ADEC_EPROM_NONE    2'h3
`define ADEC_SEL_NONE      8'hFF
`define ADEC_IO_HI_OFF     4'hF
`define ADEC_IO_LOCAL      4'h0

// Map numbers and block positions
`define ADEC_MAP_LOW_RAM_EPROM  3'h1
`define ADEC_MAP_HIGH_RAM_EPROM 3'h3
`define ADEC_BLK_FIRST     5'h00
`define ADEC_BLK_SECOND    5'h01
`define ADEC_BLK_FOURTH    5'h03
`define ADEC_BLK_PRE_TOP2  5'h1C
`define ADEC_BLK_TOP2      5'h1E
`define ADEC_BLK_LAST      5'h1F

// Io block numbers
`define ADEC_IO_RESERVED_BLK 3'h3

// Pipeline latency in register stages, input to output
`define ADEC_LATENCY       2

`endif

// >>> src/adec_pkg.sv
package adec_pkg;

  typedef logic [0:14] adec_addr_t;
  typedef logic [2:0]  adec_map_t;
  typedef logic [3:0]  adec_word_t;
  typedef logic [7:0]  adec_index_t;

  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_READ,
    CYC_WRITE,
    CYC_IO
  } adec_cycle_e;

  typedef struct packed {
    adec_cycle_e kind;
    logic        a4;
    logic        mem_n;
    logic [3:0]  io_hi;
    logic [2:0]  io_blk;
  } adec_stage_s;

endpackage : adec_pkg

// >>> src/adec_tbl_if.sv
`timescale 1ns/100ps
interface adec_tbl_if (
  input wire logic clk,
  input wire logic rst_n
);
  import adec_pkg::*;

  logic        ce;
  adec_index_t index;
  adec_word_t  data;

  modport client (input clk, input rst_n, output ce, output index, input data);
  modport lut    (input clk, input rst_n, input ce, input index, output data);
endinterface : adec_tbl_if

// >>> src/adec_rom.sv
`timescale 1ns/100ps
`include "adec_params.svh"
module adec_rom (
  adec_tbl_if.lut port
);
  import adec_pkg::*;

  // Map word lookup, zero bits are active
  function automatic adec_word_t tbl_word(input adec_index_t idx);
    logic [2:0] m;
    logic [4:0] b;
    adec_word_t w;
    m = idx[7:5];
    b = idx[4:0];
    w = `ADEC_TBL_OFF;
    case (m)
      3'h0, 3'h4: begin
        if (b <= `ADEC_BLK_SECOND) w = 4'h6;
      end
      3'h1: begin
        if (b <= `ADEC_BLK_SECOND) w = 4'h6;
        else if (b >= `ADEC_BLK_TOP2) w = 4'hA;
        else if (b >= `ADEC_BLK_PRE_TOP2) w = 4'hC;
      end
      3'h2, 3'h6: begin
        if (b >= `ADEC_BLK_TOP2) w = 4'h6;
      end
      3'h3: begin
        if (b <= `ADEC_BLK_SECOND) w = 4'hC;
        else if (b <= `ADEC_BLK_FOURTH) w = 4'hA;
        else if (b >= `ADEC_BLK_TOP2) w = 4'h6;
      end
      3'h5: begin
        if (b <= `ADEC_BLK_SECOND) w = 4'h6;
        else if (b == `ADEC_BLK_TOP2) w = 4'hC;
        else if (b == `ADEC_BLK_LAST) w = 4'hA;
      end
      3'h7: begin
        if (b == `ADEC_BLK_FIRST) w = 4'hC;
        else if (b == `ADEC_BLK_SECOND) w = 4'hA;
        else if (b >= `ADEC_BLK_TOP2) w = 4'h6;
      end
      default: w = `ADEC_TBL_OFF;
    endcase
    return w;
  endfunction : tbl_word

  // Registered table read
  always_ff @(posedge port.clk) begin
    if (!port.rst_n) begin
      port.data <= `ADEC_TBL_OFF;
    end else if (port.ce) begin
      port.data <= tbl_word(port.index);
    end
  end

  chk_high_ram_word: assert property (
    @(posedge port.clk) disable iff (!port.rst_n)
    port.ce && port.index == 8'h5E |=> port.data == 4'h6)
    else $error("map 2 top block word wrong");

endmodule : adec_rom

// >>> test/adec_cpu_model.sv
`timescale 1ns/100ps
module adec_cpu_model
  import adec_pkg::*;
(
  input  wire logic clk,
  output adec_addr_t addr,
  output logic       mem_n,
  output logic       rd,
  output logic       wr_n
);
  initial begin
    addr  = '0;
    mem_n = 1'b1;
    rd    = 1'b0;
    wr_n  = 1'b1;
  end
  // Opens a cycle, read strobe together with it
  task automatic start(input adec_addr_t a, input logic mem, input logic read);
    @(posedge clk);
    addr  <= a;
    mem_n <= ~mem;
    rd    <= mem & read;
  endtask : start
  // Write strobe only a cycle after the open
  task automatic strobe_write();
    @(posedge clk);
    wr_n <= 1'b0;
  endtask : strobe_write
  // Ends cycle, old address no longer shown
  task automatic finish();
    @(posedge clk);
    addr  <= ~addr;
    mem_n <= 1'b1;
    rd    <= 1'b0;
    wr_n  <= 1'b1;
  endtask : finish
endmodule : adec_cpu_model

// >>> test/adec_top_test.sv
`timescale 1ns/100ps
module adec_top_test;
  import adec_pkg::*;
  typedef struct packed {
    adec_map_t   map;
    logic [15:0] baddr;
    adec_cycle_e kind;
    logic [4:0]  mem;
  } adec_row_s;
  localparam int N_ROWS = 26;
  // Idle kind: cycle open, no strobe
  localparam adec_row_s ROWS [N_ROWS] = '{
    '{3'h3, 16'hF000, CYC_READ, 5'h16}, '{3'h3, 16'hF800, CYC_READ, 5'h0E},
    '{3'h3, 16'h0000, CYC_READ, 5'h1C}, '{3'h3, 16'h1000, CYC_READ, 5'h1A},
    '{3'h3, 16'h8000, CYC_READ, 5'h1F}, '{3'h3, 16'h0100, CYC_READ, 5'h1C},
    '{3'h3, 16'h0000, CYC_IDLE, 5'h1C}, '{3'h3, 16'hF000, CYC_IDLE, 5'h1E},
    '{3'h1, 16'h0000, CYC_READ, 5'h16}, '{3'h1, 16'hE000, CYC_READ, 5'h1C},
    '{3'h1, 16'hF800, CYC_READ, 5'h1A}, '{3'h5, 16'hF000, CYC_READ, 5'h1C},
    '{3'h5, 16'hF800, CYC_READ, 5'h1A}, '{3'h7, 16'h0000, CYC_READ, 5'h1C},
    '{3'h7, 16'h0800, CYC_READ, 5'h1A}, '{3'h7, 16'hF800, CYC_READ, 5'h0E},
    '{3'h7, 16'hE000, CYC_READ, 5'h1F}, '{3'h0, 16'h0800, CYC_READ, 5'h0E},
    '{3'h0, 16'hF000, CYC_READ, 5'h1F}, '{3'h2, 16'hF000, CYC_READ, 5'h16},
    '{3'h2, 16'h0000, CYC_READ, 5'h1F}, '{3'h4, 16'h0000, CYC_READ, 5'h16},
    '{3'h6, 16'hF800, CYC_READ, 5'h0E}, '{3'h6, 16'h0000, CYC_READ, 5'h1F},
    '{3'h3, 16'hF000, CYC_WRITE, 5'h16}, '{3'h3, 16'hF800, CYC_WRITE, 5'h0E}};

  logic       clk;
  logic       rst_n;
  logic       ce;
  adec_map_t  map_sel;
  adec_addr_t addr;
  logic       mem_n;
  logic       rd;
  logic       wr_n;
  logic [1:0] ram_cs_n;
  logic [1:0] eprom_cs_n;
  logic       onb_n;
  logic       io_sp;
  logic       ext_n;
  logic [7:0] sel_n;
  int         n_errors;
  int         compares;

  adec_top dut_u (.CORE_CLK(clk), .RESETN(rst_n), .CE(ce), .ADDR(addr),
    .MEMORY_CYCLE_N(mem_n), .READ_STROBE(rd), .WRITE_STROBE_N(wr_n), .MAP_SEL(map_sel),
    .RAM_CS_N(ram_cs_n), .EPROM_CS_N(eprom_cs_n), .ONBOARD_MEM_N(onb_n),
    .ONBOARD_IO_SPACE(io_sp), .EXT_IO_BUF_EN_N(ext_n), .IO_BLOCK_SELECT_N(sel_n));
  adec_cpu_model cpu_u (.clk(clk), .addr(addr), .mem_n(mem_n), .rd(rd), .wr_n(wr_n));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic cmp_mem(input logic [4:0] exp);
    compares++;
    if ({ram_cs_n, eprom_cs_n, onb_n} !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t mem got %h exp %h", $time, {ram_cs_n, eprom_cs_n, onb_n}, exp);
    end
  endtask : cmp_mem

  task automatic cmp_io(input logic [7:0] exp);
    logic [9:0] want;
    want = {exp != 8'hFF, exp != 8'hFF, exp};
    compares++;
    if ({io_sp, ext_n, sel_n} !== want) begin
      n_errors++;
      $display("MISMATCH t=%0t io got %h exp %h", $time, {io_sp, ext_n, sel_n}, want);
    end
  endtask : cmp_io

  // Drives one cycle, returns once its result has settled
  task automatic run(input adec_row_s r);
    @(posedge clk);
    map_sel <= r.map;
    cpu_u.start(r.baddr[15:1], r.kind != CYC_IO, r.kind == CYC_READ);
    if (r.kind == CYC_WRITE) cpu_u.strobe_write();
    repeat (2) @(posedge clk);
    #1;
  endtask : run

  initial begin
    #20000;
    n_errors++;
    wrap_up();
  end

  initial begin
    rst_n    = 1'b0;
    ce       = 1'b1;
    map_sel  = '0;
    n_errors = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < N_ROWS; i++) begin
      run(ROWS[i]);
      cmp_mem(ROWS[i].mem);
      cmp_io(8'hFF);
      cpu_u.finish();
    end
    $display("Test table rows done");
    run('{3'h3, 16'hF000, CYC_IDLE, 5'h1E});
    repeat (2) @(posedge clk);
    #1;
    cmp_mem(5'h1E);
    cpu_u.strobe_write();
    repeat (2) @(posedge clk);
    #1;
    cmp_mem(5'h16);
    cpu_u.finish();
    $display("Test write strobe done");
    for (int k = 0; k < 10; k++) begin
      run('{3'h0, 16'(k << 6), CYC_IO, 5'h1F});
      cmp_mem(5'h1F);
      cmp_io(k < 8 ? ~(8'h01 << k) : 8'hFF);
      cpu_u.finish();
    end
    $display("Test io blocks done");
    run('{3'h3, 16'hF000, CYC_READ, 5'h16});
    cmp_mem(5'h16);
    @(posedge clk);
    ce <= 1'b0;
    cpu_u.finish();
    repeat (3) @(posedge clk);
    #1;
    cmp_mem(5'h16);
    cmp_io(8'hFF);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    cmp_mem(5'h1F);
    cmp_io(8'hFF);
    $display("Test clock enable done");
    run('{3'h3, 16'hF000, CYC_READ, 5'h16});
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    cmp_mem(5'h1F);
    cmp_io(8'hFF);
    @(posedge clk);
    rst_n <= 1'b1;
    cpu_u.finish();
    #1;
    cmp_mem(5'h1F);
    cmp_io(8'hFF);
    @(posedge clk);
    #1;
    cmp_mem(5'h16);
    $display("Test reset done");
    wrap_up();
  end
endmodule : adec_top_test
